// File: core/psbc_dev.sv
// Chosen here: the two-wire slave port and the module register map logic.
`timescale 1ns/1ps
`default_nettype none
module psbc_dev import psbc_pkg::*; #(
    parameter int INIT_CYC = INIT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    psbc_if.dev lk,
    input wire logic [NLANES-1:0] lane_fault,
    output logic [NLANES-1:0] lane_tx_disable,
    output logic low_power_active,
    output logic module_ready
);
    ////////////////////////////////////////////////////////////////
    // Pin synchronisers and bus event detection
    logic [4:0] sy1_q;
    logic [4:0] sy2_q;
    logic scl_p_q;
    logic sda_p_q;
    wire logic scl_s = sy2_q[4];
    wire logic sda_s = sy2_q[3];
    wire logic sel = !sy2_q[2];
    wire logic rstpin_s = sy2_q[1];
    wire logic lp_s = sy2_q[0];
    wire logic scl_rise = scl_s && !scl_p_q;
    wire logic scl_fall = !scl_s && scl_p_q;
    wire logic start = scl_s && scl_p_q && sda_p_q && !sda_s;
    wire logic stop = scl_s && scl_p_q && !sda_p_q && sda_s;

    // Two flops on every pin before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_q <= PIN_IDLE;
            sy2_q <= PIN_IDLE;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            sy1_q <= {lk.scl, lk.sda, lk.module_select_n, lk.module_reset_n, lk.low_power_select};
            sy2_q <= sy1_q;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Reset pin filter and initialisation timer
    logic [15:0] rlo_q;
    logic [31:0] init_q;
    logic ready_q;
    wire logic soft_rst = !rstpin_s && (rlo_q == 16'(RST_MIN_CYCLES));
    wire logic done_pulse = (init_q == 32'h0) && !ready_q && !soft_rst;

    // Count low time; shorter pulses are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rlo_q <= 16'h0;
        end else if (rstpin_s) begin
            rlo_q <= 16'h0;
        end else if (!soft_rst) begin
            rlo_q <= rlo_q + 16'h1;
        end
    end

    // Not-ready until the interval runs out after power-up or reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_q <= 32'(INIT_CYC);
            ready_q <= 1'b0;
        end else if (soft_rst) begin
            init_q <= 32'(INIT_CYC);
            ready_q <= 1'b0;
        end else if (init_q != 32'h0) begin
            init_q <= init_q - 32'h1;
        end else begin
            ready_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Two-wire slave
    psbc_sl_st_type st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] tx_q, tx_d;
    logic [7:0] ptr_q, ptr_d;
    logic oe_q, oe_d;
    logic rw_q, rw_d;
    logic first_q, first_d;
    logic [7:0] rd_data;
    wire logic wr_stb = scl_fall && sel && !soft_rst && (st_q == S_WR) && (bit_q == 4'h8) && !first_q;

    // Byte engine: sample on rise, drive on fall
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        oe_d = oe_q;
        rw_d = rw_q;
        first_d = first_q;
        if (!sel || soft_rst) begin
            st_d = S_IDLE;
            oe_d = 1'b0;
        end else if (start) begin
            st_d = S_ADDR;
            bit_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop) begin
            st_d = S_IDLE;
            oe_d = 1'b0;
        end else if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
            if (st_q == S_RD) begin
                tx_d = {tx_q[6:0], 1'b0};
            end
        end else if (scl_fall) begin
            unique case (st_q)
                S_ADDR: begin
                    if (bit_q == 4'h8) begin
                        if (sh_q[7:1] == DEV_ADDR) begin
                            st_d = S_AACK;
                            oe_d = 1'b1;
                            rw_d = sh_q[0];
                        end else begin
                            st_d = S_IDLE;
                        end
                    end
                end
                S_AACK: begin
                    bit_d = 4'h0;
                    if (rw_q) begin
                        st_d = S_RD;
                        tx_d = rd_data;
                        oe_d = !rd_data[7];
                    end else begin
                        st_d = S_WR;
                        oe_d = 1'b0;
                        first_d = 1'b1;
                    end
                end
                S_WR: begin
                    if (bit_q == 4'h8) begin
                        st_d = S_WACK;
                        oe_d = 1'b1;
                        first_d = 1'b0;
                        ptr_d = first_q ? sh_q : ptr_q + 8'h01;
                    end
                end
                S_WACK: begin
                    st_d = S_WR;
                    oe_d = 1'b0;
                    bit_d = 4'h0;
                end
                S_RD: begin
                    if (bit_q == 4'h8) begin
                        st_d = S_RACK;
                        oe_d = 1'b0;
                        ptr_d = ptr_q + 8'h01;
                    end else begin
                        oe_d = !tx_q[7];
                    end
                end
                S_RACK: begin
                    bit_d = 4'h0;
                    if (sh_q[0]) begin
                        st_d = S_IDLE;
                    end else begin
                        st_d = S_RD;
                        tx_d = rd_data;
                        oe_d = !rd_data[7];
                    end
                end
                default: ;
            endcase
        end
    end

    // Slave state flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            {bit_q, sh_q, tx_q, ptr_q} <= 28'h0;
            {oe_q, rw_q, first_q} <= 3'h0;
        end else begin
            st_q <= st_d;
            {bit_q, sh_q, tx_q, ptr_q} <= {bit_d, sh_d, tx_d, ptr_d};
            {oe_q, rw_q, first_q} <= {oe_d, rw_d, first_d};
        end
    end

    ////////////////////////////////////////////////////////////////
    // Memory map
    logic [7:0] flags_q;
    logic [7:0] en_q;
    logic [3:0] ldis_q;
    logic pwr_q;
    logic lp_q;
    logic irq_q;
    wire logic [7:0] fl_set = {lane_fault, 3'h0, done_pulse};
    wire logic [7:0] fl_clr = (wr_stb && ptr_q == MM_CLEAR) ? sh_q : 8'h00;
    wire logic [7:0] status = {5'h0, lp_q, irq_q, !ready_q};

    // Read selection; unmapped offsets read zero
    assign rd_data = (ptr_q == MM_STATUS) ? status :
        (ptr_q == MM_FLAGS) ? flags_q :
        (ptr_q == MM_ENABLE) ? en_q :
        (ptr_q == MM_LANE_DIS) ? {4'h0, ldis_q} :
        (ptr_q == MM_POWER) ? {7'h0, pwr_q} : 8'h00;

    // Settings return to defaults on a long reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= ENABLE_RST;
            ldis_q <= LANE_DIS_RST;
            pwr_q <= 1'b0;
        end else if (soft_rst) begin
            en_q <= ENABLE_RST;
            ldis_q <= LANE_DIS_RST;
            pwr_q <= 1'b0;
        end else if (wr_stb) begin
            if (ptr_q == MM_ENABLE) en_q <= sh_q;
            if (ptr_q == MM_LANE_DIS) ldis_q <= sh_q[3:0];
            if (ptr_q == MM_POWER) pwr_q <= sh_q[0];
        end
    end

    // Sticky flags, set beats clear, and pin drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= 8'h00;
            lp_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            flags_q <= soft_rst ? 8'h00 : ((flags_q & ~fl_clr) | fl_set);
            lp_q <= lp_s || pwr_q;
            irq_q <= |(flags_q & en_q) && !soft_rst;
        end
    end

    // Open-drain pins only ever pull low
    assign lk.sda_dev_o = 1'b0;
    assign lk.sda_dev_oe = oe_q;
    assign lk.irq_o = 1'b0;
    assign lk.irq_oe = irq_q;
    assign lk.present_o = 1'b0;
    assign lk.present_oe = 1'b1;
    assign lane_tx_disable = ldis_q;
    assign low_power_active = lp_q;
    assign module_ready = ready_q;
endmodule
`default_nettype wire

// File: core/psbc_host.sv
`timescale 1ns/1ps
`default_nettype none
module psbc_host import psbc_pkg::*; #(
    parameter int QTR = SCL_QTR_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    psbc_if.host lk
);
    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] sy1_q;
    logic [2:0] sy2_q;
    wire logic sda_s = sy2_q[2];
    wire logic pres_s = sy2_q[1];
    wire logic mirq_s = sy2_q[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_q <= 3'h7;
            sy2_q <= 3'h7;
        end else begin
            sy1_q <= {lk.sda, lk.module_present_n, lk.module_irq_n};
            sy2_q <= sy1_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // APB decode
    logic [2:0] ctrl_q;
    logic [2:0] int_q;
    logic [2:0] ien_q;
    logic [7:0] off_q;
    logic [7:0] wd_q;
    logic [7:0] rdata_q;
    logic rd_q;
    logic nack_q, nack_d;
    logic rpend_q;
    psbc_hm_st_type hs_q, hs_d;
    wire logic busy = (hs_q != H_IDLE);
    wire logic wr = psel && penable && pwrite;
    wire logic a_ctrl = (paddr == A_CTRL);
    wire logic a_cmd = (paddr == A_CMD);
    wire logic a_stat = (paddr == A_STATUS);
    wire logic a_rd = (paddr == A_RDATA);
    wire logic a_ist = (paddr == A_INT_STAT);
    wire logic a_icl = (paddr == A_INT_CLR);
    wire logic a_ien = (paddr == A_INT_EN);
    wire logic hit = a_ctrl || a_cmd || a_stat || a_rd || a_ist || a_icl || a_ien;
    wire logic cmd_go = wr && a_cmd && !busy;
    wire logic [31:0] rd_mux = a_ctrl ? {29'h0, ctrl_q} :
        a_stat ? {28'h0, !mirq_s, !pres_s, nack_q, busy} :
        a_rd ? {24'h0, rdata_q} :
        a_ist ? {29'h0, int_q} :
        a_ien ? {29'h0, ien_q} : 32'h0;

    // Zero-wait slave, answer latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= rd_mux;
            pslverr <= !hit;
        end
    end
    assign pready = 1'b1;

    ////////////////////////////////////////////////////////////////
    // Control, command and interrupt registers
    logic fin;
    logic [7:0] hrx_q;
    logic [2:0] step_q;
    wire logic rst_done = !mirq_s && rpend_q && !ctrl_q[CT_RST];
    wire logic mod_ev = !mirq_s && !rpend_q;
    wire logic [2:0] iset = {rst_done, mod_ev, fin};
    wire logic [2:0] iclr = (wr && a_icl) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            ien_q <= 3'h0;
            {off_q, wd_q, rd_q} <= 17'h0;
        end else begin
            if (wr && a_ctrl) ctrl_q <= pwdata[2:0];
            if (wr && a_ien) ien_q <= pwdata[2:0];
            if (cmd_go) {off_q, wd_q, rd_q} <= {pwdata[7:0], pwdata[CMD_WD_LSB+:8], pwdata[CMD_RD]};
        end
    end

    // Status held back while a reset is pending, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_q <= 3'h0;
            rpend_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            int_q <= (int_q & ~iclr) | iset;
            if (wr && a_ctrl && pwdata[CT_RST]) rpend_q <= 1'b1;
            else if (rst_done) rpend_q <= 1'b0;
            if (fin && rd_q) rdata_q <= hrx_q;
        end
    end
    assign irq = |(int_q & ien_q);

    ////////////////////////////////////////////////////////////////
    // Two-wire master, four quarters per bit
    logic [1:0] q_q, q_d;
    logic [15:0] div_q, div_d;
    logic [2:0] step_d;
    logic [3:0] hbit_q, hbit_d;
    logic [7:0] htx_q, htx_d;
    logic [7:0] hrx_d;
    logic scl_q, scl_d;
    logic hoe_q, hoe_d;
    logic sel_n_q;
    wire logic last_rd = rd_q && (step_q == 3'h3);
    wire logic last = last_rd || (!rd_q && step_q == 3'h2);
    wire logic [15:0] qload = 16'(QTR - 1);

    always_comb begin
        hs_d = hs_q;
        {q_d, div_d, step_d, hbit_d} = {q_q, div_q, step_q, hbit_q};
        {htx_d, hrx_d, nack_d, scl_d, hoe_d} = {htx_q, hrx_q, nack_q, scl_q, hoe_q};
        fin = 1'b0;
        if (hs_q == H_IDLE) begin
            {scl_d, hoe_d, q_d, div_d} = {2'b10, 2'h0, qload};
            if (cmd_go) begin
                hs_d = H_START;
                step_d = 3'h0;
                htx_d = {DEV_ADDR, 1'b0};
                nack_d = 1'b0;
            end
        end else if (div_q != 16'h0) begin
            div_d = div_q - 16'h1;
        end else begin
            div_d = qload;
            q_d = q_q + 2'h1;
            unique case (hs_q)
                H_START: begin
                    if (q_q == 2'h1) hoe_d = 1'b1;
                    if (q_q == 2'h2) scl_d = 1'b0;
                    if (q_q == 2'h3) begin
                        hs_d = H_BYTE;
                        hbit_d = 4'h0;
                    end
                end
                H_RSTART: begin
                    if (q_q == 2'h0) {scl_d, hoe_d} = 2'b00;
                    if (q_q == 2'h1) scl_d = 1'b1;
                    if (q_q == 2'h2) hoe_d = 1'b1;
                    if (q_q == 2'h3) begin
                        scl_d = 1'b0;
                        hs_d = H_BYTE;
                        hbit_d = 4'h0;
                    end
                end
                H_STOP: begin
                    if (q_q == 2'h0) {scl_d, hoe_d} = 2'b01;
                    if (q_q == 2'h1) scl_d = 1'b1;
                    if (q_q == 2'h2) hoe_d = 1'b0;
                    if (q_q == 2'h3) begin
                        hs_d = H_IDLE;
                        fin = 1'b1;
                    end
                end
                H_BYTE: begin
                    if (q_q == 2'h0) {scl_d, hoe_d} = {1'b0, hbit_q < 4'h8 && !htx_q[7]};
                    if (q_q == 2'h1) scl_d = 1'b1;
                    if (q_q == 2'h2 && hbit_q < 4'h8) hrx_d = {hrx_q[6:0], sda_s};
                    if (q_q == 2'h2 && hbit_q == 4'h8 && !last_rd) nack_d = sda_s;
                    if (q_q == 2'h3) begin
                        scl_d = 1'b0;
                        if (hbit_q < 4'h8) begin
                            {htx_d, hbit_d} = {htx_q[6:0], 1'b0, hbit_q + 4'h1};
                        end else if (nack_q || last) begin
                            hs_d = H_STOP;
                        end else if (rd_q && step_q == 3'h1) begin
                            hs_d = H_RSTART;
                            {step_d, htx_d} = {3'h2, DEV_ADDR, 1'b1};
                        end else begin
                            {step_d, hbit_d} = {step_q + 3'h1, 4'h0};
                            htx_d = (step_q == 3'h0) ? off_q : (rd_q ? 8'hff : wd_q);
                        end
                    end
                end
                default: hs_d = H_IDLE;
            endcase
        end
    end

    // Master flops; select held low through each transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_q <= H_IDLE;
            {q_q, div_q, step_q, hbit_q, htx_q, hrx_q} <= 41'h0;
            {nack_q, scl_q, hoe_q, sel_n_q} <= 4'b0101;
        end else begin
            hs_q <= hs_d;
            {q_q, div_q, step_q, hbit_q, htx_q, hrx_q} <= {q_d, div_d, step_d, hbit_d, htx_d, hrx_d};
            {nack_q, scl_q, hoe_q} <= {nack_d, scl_d, hoe_d};
            sel_n_q <= !(ctrl_q[CT_SEL] || hs_d != H_IDLE);
        end
    end

    assign lk.scl = scl_q;
    assign lk.sda_host_o = 1'b0;
    assign lk.sda_host_oe = hoe_q;
    assign lk.module_select_n = sel_n_q;
    assign lk.module_reset_n = !ctrl_q[CT_RST];
    assign lk.low_power_select = ctrl_q[CT_LP];
endmodule
`default_nettype wire

// File: core/psbc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psbc_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda;
    logic module_select_n;
    logic module_reset_n;
    logic low_power_select;
    logic present_o;
    logic present_oe;
    logic module_present_n;
    logic irq_o;
    logic irq_oe;
    logic module_irq_n;

    // Open-drain wires with host pull-ups
    assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);
    assign module_present_n = present_oe ? present_o : 1'b1;
    assign module_irq_n = irq_oe ? irq_o : 1'b1;

    modport dev (input scl, sda, module_select_n, module_reset_n, low_power_select,
        output sda_dev_o, sda_dev_oe, present_o, present_oe, irq_o, irq_oe);
    modport host (output scl, sda_host_o, sda_host_oe, module_select_n, module_reset_n,
        low_power_select, input sda, module_present_n, module_irq_n);
endinterface
`default_nettype wire

// File: core/psbc_pkg.sv
package psbc_pkg;
    // Clock and timing
    localparam int CLK_HZ = 50_000_000;
    localparam int INIT_TIME_MS = 2000;
    localparam int INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
    localparam int RST_MIN_US = 10;
    localparam int RST_MIN_CYCLES = RST_MIN_US * (CLK_HZ / 1_000_000);
    localparam int SCL_KHZ = 100;
    localparam int SCL_QTR_CYCLES = CLK_HZ / (SCL_KHZ * 1000 * 4);
    localparam int NLANES = 4;

    // Two-wire device address and module memory map
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic [7:0] MM_STATUS = 8'h00;
    localparam logic [7:0] MM_FLAGS = 8'h01;
    localparam logic [7:0] MM_ENABLE = 8'h02;
    localparam logic [7:0] MM_CLEAR = 8'h03;
    localparam logic [7:0] MM_LANE_DIS = 8'h04;
    localparam logic [7:0] MM_POWER = 8'h05;
    localparam int ST_DNR = 0;
    localparam int ST_IRQ = 1;
    localparam int ST_LP = 2;
    localparam int FL_DONE = 0;
    localparam int FL_FAULT_LSB = 4;
    localparam logic [7:0] ENABLE_RST = 8'hf1;
    localparam logic [3:0] LANE_DIS_RST = 4'h0;
    localparam logic [4:0] PIN_IDLE = 5'h1e;

    // Host controller APB map
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_CMD = 12'h004;
    localparam logic [11:0] A_STATUS = 12'h008;
    localparam logic [11:0] A_RDATA = 12'h00c;
    localparam logic [11:0] A_INT_STAT = 12'h010;
    localparam logic [11:0] A_INT_CLR = 12'h014;
    localparam logic [11:0] A_INT_EN = 12'h018;
    localparam int CT_SEL = 0;
    localparam int CT_RST = 1;
    localparam int CT_LP = 2;
    localparam logic [2:0] CTRL_RST = 3'h4;
    localparam int CMD_RD = 8;
    localparam int CMD_WD_LSB = 16;
    localparam int IT_DONE = 0;
    localparam int IT_MODIRQ = 1;
    localparam int IT_RSTDONE = 2;

    // Module slave states, Gray coded along the path
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_ADDR = 3'b001, S_AACK = 3'b011, S_WR = 3'b010,
        S_WACK = 3'b110, S_RD = 3'b111, S_RACK = 3'b101
    } psbc_sl_st_type;

    // Host master states
    typedef enum logic [2:0] {
        H_IDLE = 3'b000, H_START = 3'b001, H_BYTE = 3'b011,
        H_RSTART = 3'b010, H_STOP = 3'b110
    } psbc_hm_st_type;
endpackage

// File: verification/pluggable_module_sideband_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pluggable_module_sideband_control_tb_top import psbc_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, lp_act, ready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] lane_fault, tx_dis;
    int err_count, tests_run;
    psbc_if lk();
    psbc_dev #(.INIT_CYC(200)) psbc_dev_inst (.pclk(pclk), .presetn(presetn), .lk(lk),
        .lane_fault(lane_fault), .lane_tx_disable(tx_dis), .low_power_active(lp_act), .module_ready(ready));
    psbc_host #(.QTR(10)) psbc_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .lk(lk));
    psbc_asserts #(.INIT_CYC(200)) psbc_asserts_inst (.pclk(pclk), .presetn(presetn), .scl(lk.scl),
        .sda(lk.sda), .sda_dev_o(lk.sda_dev_o), .sda_dev_oe(lk.sda_dev_oe), .module_select_n(lk.module_select_n),
        .module_reset_n(lk.module_reset_n), .module_present_n(lk.module_present_n), .irq_o(lk.irq_o),
        .irq_oe(lk.irq_oe), .module_irq_n(lk.module_irq_n));
    ////////////////////////////////////////////////////////////////
    // Verdict and shared bus tasks
    task automatic test_done();
        if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) begin
            err_count++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never reassigns psel in this step
        @(posedge pclk);
    endtask
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        for (int i = 0; i < 4000; i++) begin
            apb(1'b0, a, 32'h0);
            if ((rd & m) === v) return;
        end
        err_count++;
        test_done();
    endtask
    // One two-wire access to the module map; read data lands in rd
    task automatic mm(input logic r, input logic [7:0] off, input logic [7:0] d);
        apb(1'b1, A_CMD, {8'h0, d, 7'h0, r, off});
        repeat (2) @(posedge pclk);
        poll(A_STATUS, 32'h1, 32'h0);
        if (r) apb(1'b0, A_RDATA, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_power();
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd[2:0], CTRL_RST);
        poll(A_INT_STAT, 32'h2, 32'h2);
        mm(1'b1, MM_FLAGS, 8'h0);
        chk(rd[0], 1'b1);
        mm(1'b1, MM_STATUS, 8'h0);
        chk(rd[2:0], 3'h6);
        chk({ready, lp_act}, 2'h3);
        apb(1'b0, A_STATUS, 32'h0);
        chk(rd[3:0], 4'hc);
    endtask
    task automatic t_irq();
        apb(1'b1, A_INT_EN, 32'h7);
        chk(irq, 1'b1);
        mm(1'b0, MM_CLEAR, 8'h01);
        repeat (5) @(posedge pclk);
        apb(1'b1, A_INT_CLR, 32'h7);
        chk({lk.module_irq_n, irq}, 2'h2);
        lane_fault <= 4'h4;
        poll(A_INT_STAT, 32'h2, 32'h2);
        mm(1'b1, MM_FLAGS, 8'h0);
        chk(rd[7:4], 4'h4);
        lane_fault <= 4'h0;
        mm(1'b0, MM_CLEAR, 8'hf0);
        apb(1'b1, A_INT_EN, 32'h0);
        chk(irq, 1'b0);
    endtask
    task automatic t_lane();
        mm(1'b0, MM_LANE_DIS, 8'h0a);
        chk(tx_dis, 4'ha);
        mm(1'b1, MM_LANE_DIS, 8'h0);
        chk(rd[3:0], 4'ha);
        apb(1'b1, A_CTRL, 32'h0);
        repeat (6) @(posedge pclk);
        chk(lp_act, 1'b0);
        mm(1'b0, MM_POWER, 8'h01);
        chk(lp_act, 1'b1);
        apb(1'b0, 12'h0fc, 32'h0);
        chk(err, 1'b1);
    endtask
    // Interrupt is up when the module reset starts, so the reset must drop it
    task automatic t_reset();
        lane_fault <= 4'h1;
        apb(1'b1, A_CTRL, 32'h2);
        repeat (560) @(posedge pclk);
        chk({ready, tx_dis, lp_act}, 6'h0);
        lane_fault <= 4'h0;
        mm(1'b0, MM_POWER, 8'h01);
        chk(rd[1:0], 2'h2);
        chk(lp_act, 1'b0);
        apb(1'b1, A_CTRL, 32'h0);
        poll(A_INT_STAT, 32'h4, 32'h4);
        mm(1'b1, MM_FLAGS, 8'h0);
        chk(rd[0], 1'b1);
        mm(1'b1, MM_LANE_DIS, 8'h0);
        chk(rd[3:0], LANE_DIS_RST);
    endtask
    ////////////////////////////////////////////////////////////////
    // Clock and main sequence
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, lane_fault} = '0;
        err_count = 0;
        tests_run = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_power();
        t_irq();
        t_lane();
        t_reset();
        test_done();
    end
endmodule
`default_nettype wire

// File: verification/psbc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module psbc_asserts #(
    parameter int INIT_CYC = 200
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic module_present_n,
    input wire logic irq_o,
    input wire logic irq_oe,
    input wire logic module_irq_n
);
    logic [31:0] up_q;
    logic [9:0] lo_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // Cycles since release, and length of a module reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_q <= '0;
            lo_q <= '0;
        end else begin
            up_q <= up_q + {31'h0, up_q < INIT_CYC};
            lo_q <= module_reset_n ? 10'h0 : lo_q + {9'h0, lo_q < 10'h3ff};
        end
    end
    ////////////////////////////////////////////////////////////////
    sel_release_a: assert property (module_select_n [*6] |-> !sda_dev_oe)
        else $error("data line driven while unselected");
    od_irq_a: assert property (irq_oe |-> !irq_o)
        else $error("interrupt line driven high");
    od_sda_a: assert property (sda_dev_oe |-> !sda_dev_o)
        else $error("data line driven high");
    present_low_a: assert property (!module_present_n)
        else $error("presence line not pulled low");
    sda_edge_a: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("data changed while clock high");
    soft_rst_a: assert property (lo_q > 10'h208 |-> !irq_oe)
        else $error("interrupt held during module reset");
    init_quiet_a: assert property (up_q < INIT_CYC |-> module_irq_n)
        else $error("interrupt before init interval");
    desel_idle_a: assert property ($rose(module_select_n) |-> scl && sda)
        else $error("deselect on a busy bus");
endmodule
`default_nettype wire
